// File: ssp_pkg.sv
// shared constants for the sensor serial port, both ends
package ssp_pkg;
  localparam int          SSP_ADDR_W      = 7;       // register address bits
  localparam int          SSP_DATA_W      = 8;       // register data bits
  localparam int          SSP_FRAME_BITS  = 16;      // control byte + data byte
  localparam logic [3:0]  SSP_CNT_RESET   = 4'h0;    // bit count at frame start
  localparam logic [3:0]  SSP_CNT_DATA    = 4'h8;    // first data bit position
  localparam logic [3:0]  SSP_CNT_LAST    = 4'hf;    // last bit of a byte
  localparam logic [6:0]  SSP_CTL_ADDR    = 7'h4b;   // control register address
  localparam int          SSP_PWR_BIT     = 0;       // power control bit
  localparam int          SSP_3W_BIT      = 2;       // three_wire_enable bit
  localparam logic [7:0]  SSP_CTL_RESET   = 8'h00;   // 4-wire after reset
  localparam logic        SSP_RW_WRITE    = 1'b0;    // direction flag values
  localparam logic        SSP_RW_READ     = 1'b1;
  // timing of the host-made serial clock and chip select
  localparam int          SSP_CLK_NS      = 5;       // system clock period
  localparam int          SSP_SCK_NS      = 100;     // serial clock period
  localparam int          SSP_CS_SETUP_NS = 20;      // chip select setup, min
  localparam int          SSP_CS_HOLD_NS  = 40;      // chip select hold, min
  localparam logic [7:0]  SSP_HALF_CYC    =
    8'((SSP_SCK_NS / 2 + SSP_CLK_NS - 1) / SSP_CLK_NS);
  localparam logic [7:0]  SSP_SETUP_CYC   =
    8'((SSP_CS_SETUP_NS + SSP_CLK_NS - 1) / SSP_CLK_NS);
  localparam logic [7:0]  SSP_HOLD_CYC    =
    8'((SSP_CS_HOLD_NS + SSP_CLK_NS - 1) / SSP_CLK_NS);
  // host sequencer states
  typedef enum logic [3:0] {
    SSP_IDLE  = 4'b0001,
    SSP_SETUP = 4'b0010,
    SSP_SHIFT = 4'b0100,
    SSP_HOLD  = 4'b1000
  } ssp_state_t;
endpackage : ssp_pkg

// File: ssp_link_if.sv
// serial link between host master and sensor port, with pin resolution
`timescale 1ns/1ps
`default_nettype none
interface ssp_link_if;
  logic sck;           // serial clock, made by the host
  logic chip_select_low; // frame select, active low
  logic protocol_select_pin; // low selects this port, strapped by bench
  logic h_sdi_o;       // host drive of serial_in_line
  logic h_sdi_oe;      // host enable of serial_in_line
  logic d_sdi_o;       // device drive of serial_in_line (3-wire)
  logic d_sdi_oe;      // device enable of serial_in_line
  logic d_sdo_o;       // device serial output
  logic d_sdo_oe;      // device enable of serial output
  logic serial_in_line; // resolved shared data line, pulled high
  logic sdo;           // resolved serial output, pulled high
  assign serial_in_line = h_sdi_oe ? h_sdi_o : (d_sdi_oe ? d_sdi_o : 1'b1);
  assign sdo            = d_sdo_oe ? d_sdo_o : 1'b1;
  modport host (
    output sck, chip_select_low, h_sdi_o, h_sdi_oe,
    input  serial_in_line, sdo
  );
  modport device (
    input  sck, chip_select_low, protocol_select_pin, serial_in_line,
    output d_sdi_o, d_sdi_oe, d_sdo_o, d_sdo_oe
  );
endinterface : ssp_link_if
`default_nettype wire

// File: ssp_device.sv
// sensor serial port slave: link logic on sck, status on clk_i
`timescale 1ns/1ps
`default_nettype none
module ssp_device (
  input  wire logic                      clk_i,      // status clock
  input  wire logic                      arst_n_i,   // async reset
  ssp_link_if.device                     link,       // serial pins
  output logic                           wr_valid_o, // register written
  output logic [ssp_pkg::SSP_ADDR_W-1:0] wr_addr_o,  // its address
  output logic [ssp_pkg::SSP_DATA_W-1:0] wr_data_o,  // its data
  output logic                           three_wire_o, // 3-wire active
  output logic                           mode11_o    // last frame mode 11
);
  import ssp_pkg::*;

  // register storage; the control register has its own reset flops
  logic [SSP_DATA_W-1:0] mem_q [2**SSP_ADDR_W];
  logic [SSP_DATA_W-1:0] ctl_q, ctl_d;           // control register
  logic [3:0]            cnt_q, cnt_d;           // rising edges seen, 15 wraps to 8
  logic [6:0]            sh_q, sh_d;             // incoming bits
  logic                  rw_q, rw_d;             // direction flag
  logic [SSP_ADDR_W-1:0] addr_q, addr_d;         // current address
  logic                  we;                     // store this byte
  logic [SSP_DATA_W-1:0] wbyte;                  // byte to store
  logic                  tgl_q, tgl_d;           // write event toggle
  logic [SSP_ADDR_W-1:0] hold_a_q, hold_a_d;     // held write address
  logic [SSP_DATA_W-1:0] hold_d_q, hold_d_d;     // held write data
  logic                  out_q, out_d;           // bit driven out
  logic                  sdo_oe_q, sdo_oe_d;     // 4-wire drive enable
  logic                  sdi_oe_q, sdi_oe_d;     // 3-wire drive enable
  logic [SSP_DATA_W-1:0] rd_byte;                // byte being read
  logic                  three_wire;             // current wiring
  logic                  frm_rst_n;              // frame alive
  logic                  mode_q;                 // sck level at select fall

  assign three_wire = ctl_q[SSP_3W_BIT];

  // a frame exists only while selected and this port is chosen; select
  // rising clears the frame because sck may stop right after the last bit
  assign frm_rst_n = arst_n_i & ~link.chip_select_low
                   & ~link.protocol_select_pin;

  // clock mode: sck high when select falls means mode 11
  always_ff @(negedge link.chip_select_low or negedge arst_n_i)
  begin
    if (!arst_n_i)
      mode_q <= 1'b0;
    else
      mode_q <= link.sck;
  end

  // next values of the receive side, sampled on rising sck
  always_comb
  begin
    cnt_d    = (cnt_q == SSP_CNT_LAST) ? SSP_CNT_DATA : cnt_q + 4'h1;
    sh_d     = {sh_q[5:0], link.serial_in_line};
    rw_d     = rw_q;
    addr_d   = addr_q;
    ctl_d    = ctl_q;
    tgl_d    = tgl_q;
    hold_a_d = hold_a_q;
    hold_d_d = hold_d_q;
    we       = 1'b0;
    wbyte    = {sh_q, link.serial_in_line};
    // first bit is the direction flag
    if (cnt_q == SSP_CNT_RESET)
      rw_d = link.serial_in_line;
    // seventh address bit completes the control byte
    if (cnt_q == SSP_CNT_DATA - 4'h1)
      addr_d = {sh_q[5:0], link.serial_in_line};
    // end of each data byte
    if (cnt_q == SSP_CNT_LAST)
    begin
      if (rw_q == SSP_RW_READ)
        addr_d = addr_q + 7'h1;
      else
      begin
        // later bytes of a long write rewrite the same address
        we       = 1'b1;
        tgl_d    = ~tgl_q;
        hold_a_d = addr_q;
        hold_d_d = wbyte;
        if (addr_q == SSP_CTL_ADDR)
          ctl_d = wbyte;
      end
    end
  end

  // frame state, cleared whenever the frame is not alive
  always_ff @(posedge link.sck or negedge frm_rst_n)
  begin
    if (!frm_rst_n)
    begin
      cnt_q  <= SSP_CNT_RESET;
      sh_q   <= 7'h00;
      rw_q   <= SSP_RW_WRITE;
      addr_q <= 7'h00;
    end
    else
    begin
      cnt_q  <= cnt_d;
      sh_q   <= sh_d;
      rw_q   <= rw_d;
      addr_q <= addr_d;
    end
  end

  // state that outlives a frame
  always_ff @(posedge link.sck or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      ctl_q    <= SSP_CTL_RESET;
      tgl_q    <= 1'b0;
      hold_a_q <= 7'h00;
      hold_d_q <= 8'h00;
    end
    else
    begin
      ctl_q    <= ctl_d;
      tgl_q    <= tgl_d;
      hold_a_q <= hold_a_d;
      hold_d_q <= hold_d_d;
    end
  end

  // register array, no reset: contents are undefined until written
  always_ff @(posedge link.sck)
  begin
    if (we)
      mem_q[addr_q] <= wbyte;
  end

  // next values of the drive side, changed on falling sck
  always_comb
  begin
    rd_byte  = (addr_q == SSP_CTL_ADDR) ? ctl_q : mem_q[addr_q];
    out_d    = rd_byte[~cnt_q[2:0]];               // msb first
    // drive only in data bits of a read
    sdo_oe_d = (rw_q == SSP_RW_READ) & cnt_q[3] & ~three_wire;
    sdi_oe_d = (rw_q == SSP_RW_READ) & cnt_q[3] & three_wire;
  end

  // drive flops; select rising releases the lines at once
  always_ff @(negedge link.sck or negedge frm_rst_n)
  begin
    if (!frm_rst_n)
    begin
      out_q    <= 1'b0;
      sdo_oe_q <= 1'b0;
      sdi_oe_q <= 1'b0;
    end
    else
    begin
      out_q    <= out_d;
      sdo_oe_q <= sdo_oe_d;
      sdi_oe_q <= sdi_oe_d;
    end
  end

  // same bit feeds both wirings; the enables pick the pin
  assign link.d_sdo_o  = out_q;
  assign link.d_sdo_oe = sdo_oe_q;
  assign link.d_sdi_o  = out_q;
  assign link.d_sdi_oe = sdi_oe_q;

  // status side: toggle and levels cross by two flops each
  logic [2:0] tgl_s_q, tgl_s_d;       // toggle sync plus edge flop
  logic [1:0] tw_s_q, tw_s_d;         // three-wire level sync
  logic [1:0] md_s_q, md_s_d;         // mode level sync
  logic       wv_d;
  logic [SSP_ADDR_W-1:0] wa_d;
  logic [SSP_DATA_W-1:0] wd_d;

  // next values on clk_i; held words stay stable long after the toggle
  // lands because the next write needs at least eight more sck edges
  always_comb
  begin
    tgl_s_d = {tgl_s_q[1:0], tgl_q};
    tw_s_d  = {tw_s_q[0], three_wire};
    md_s_d  = {md_s_q[0], mode_q};
    wv_d    = tgl_s_q[2] ^ tgl_s_q[1];
    wa_d    = wv_d ? hold_a_q : wr_addr_o;
    wd_d    = wv_d ? hold_d_q : wr_data_o;
  end

  // status registers
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      tgl_s_q      <= 3'h0;
      tw_s_q       <= 2'h0;
      md_s_q       <= 2'h0;
      wr_valid_o   <= 1'b0;
      wr_addr_o    <= 7'h00;
      wr_data_o    <= 8'h00;
      three_wire_o <= 1'b0;
      mode11_o     <= 1'b0;
    end
    else
    begin
      tgl_s_q      <= tgl_s_d;
      tw_s_q       <= tw_s_d;
      md_s_q       <= md_s_d;
      wr_valid_o   <= wv_d;
      wr_addr_o    <= wa_d;
      wr_data_o    <= wd_d;
      three_wire_o <= tw_s_q[1];
      mode11_o     <= md_s_q[1];
    end
  end
endmodule : ssp_device
`default_nettype wire

// File: ssp_host.sv
// host master: makes sck by division and runs one transfer per request
`timescale 1ns/1ps
`default_nettype none
module ssp_host #(
  parameter int NB_W = 4                          // burst length width
) (
  input  wire logic                      clk_i,
  input  wire logic                      arst_n_i,
  ssp_link_if.host                       link,
  input  wire logic                      start_i,     // request pulse
  input  wire logic                      rw_i,        // 1 read, 0 write
  input  wire logic [ssp_pkg::SSP_ADDR_W-1:0] addr_i,
  input  wire logic [ssp_pkg::SSP_DATA_W-1:0] wdata_i,
  input  wire logic [NB_W-1:0]           nbytes_i,    // read burst, 0 as 1
  input  wire logic                      three_wire_i, // use shared line
  input  wire logic                      mode11_i,    // idle sck high
  output logic                           busy_o,
  output logic                           rvalid_o,    // read byte pulse
  output logic [ssp_pkg::SSP_DATA_W-1:0] rdata_o,
  output logic                           done_o       // frame end pulse
);
  import ssp_pkg::*;

  ssp_state_t   st_q, st_d;
  logic [7:0]   div_q, div_d;        // cycles in current phase
  logic [7:0]   bit_q, bit_d;        // rising edges given
  logic [7:0]   tot_q, tot_d;        // bits in this frame
  logic [15:0]  tx_q, tx_d;          // outgoing bits, msb on the line
  logic [7:0]   rx_q, rx_d;          // incoming bits
  logic         sck_q, sck_d, cs_q, cs_d, oe_q, oe_d;
  logic         rw_q, rw_d, tw_q, tw_d, cpol_q, cpol_d;
  logic         rv_d, dn_d;
  logic [SSP_DATA_W-1:0] rd_d;
  logic [1:0]   sdi_s_q, sdo_s_q;    // pin synchronisers
  logic         miso;
  logic [NB_W:0] nb;

  assign miso = tw_q ? sdi_s_q[1] : sdo_s_q[1];

  // sequencer next state
  always_comb
  begin
    st_d = st_q; div_d = div_q + 8'h1; bit_d = bit_q; tot_d = tot_q;
    tx_d = tx_q; rx_d = rx_q; sck_d = sck_q; cs_d = cs_q; oe_d = oe_q;
    rw_d = rw_q; tw_d = tw_q; cpol_d = cpol_q;
    rv_d = 1'b0; dn_d = 1'b0; rd_d = rdata_o;
    nb   = (rw_i && nbytes_i != '0) ? {1'b0, nbytes_i} : (NB_W+1)'(1);
    case (st_q)
      SSP_IDLE:
      begin
        div_d = 8'h0;
        // idle level follows the requested mode at once, so sck has
        // settled a cycle before select falls and mode sensing sees it
        cpol_d = mode11_i;
        sck_d  = mode11_i;
        if (start_i)
        begin
          st_d   = SSP_SETUP;
          cs_d   = 1'b0;                       // open frame
          oe_d   = 1'b1;
          rw_d   = rw_i;
          tw_d   = three_wire_i;
          cpol_d = mode11_i;
          sck_d  = mode11_i;
          bit_d  = 8'h0;
          tot_d  = 8'((nb + 1'b1) * 8);
          tx_d   = {rw_i, addr_i, wdata_i};
        end
      end
      SSP_SETUP:
        if (div_q == SSP_SETUP_CYC - 8'h1)
        begin
          st_d  = SSP_SHIFT;
          div_d = 8'h0;
          sck_d = 1'b0;                        // falling edge in mode 11
        end
      SSP_SHIFT:
        if (div_q == SSP_HALF_CYC - 8'h1)
        begin
          div_d = 8'h0;
          if (!sck_q)
          begin
            // rising edge: take one bit
            sck_d = 1'b1;
            bit_d = bit_q + 8'h1;
            rx_d  = {rx_q[6:0], miso};
            if (rw_q && bit_q >= 8'h8 && bit_q[2:0] == 3'h7)
            begin
              rv_d = 1'b1;
              rd_d = {rx_q[6:0], miso};
            end
          end
          else if (bit_q == tot_q)
          begin
            st_d  = SSP_HOLD;
            sck_d = cpol_q;
          end
          else
          begin
            // falling edge: present the next bit
            sck_d = 1'b0;
            tx_d  = {tx_q[14:0], 1'b0};
            if (tw_q && rw_q && bit_q >= 8'h8)
              oe_d = 1'b0;                     // release line
          end
        end
      SSP_HOLD:
        if (div_q == SSP_HOLD_CYC - 8'h1)
        begin
          st_d = SSP_IDLE;
          cs_d = 1'b1;
          oe_d = 1'b0;
          dn_d = 1'b1;
        end
      default:
      begin
        st_d = SSP_IDLE;
        cs_d = 1'b1;
        oe_d = 1'b0;
      end
    endcase
  end

  // sequencer registers and pin synchronisers
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      st_q <= SSP_IDLE; div_q <= 8'h0; bit_q <= 8'h0; tot_q <= 8'h0;
      tx_q <= 16'h0; rx_q <= 8'h0; sck_q <= 1'b0; cs_q <= 1'b1;
      oe_q <= 1'b0; rw_q <= 1'b0; tw_q <= 1'b0; cpol_q <= 1'b0;
      rvalid_o <= 1'b0; rdata_o <= 8'h0; done_o <= 1'b0; busy_o <= 1'b0;
      sdi_s_q <= 2'h0; sdo_s_q <= 2'h0;
    end
    else
    begin
      st_q <= st_d; div_q <= div_d; bit_q <= bit_d; tot_q <= tot_d;
      tx_q <= tx_d; rx_q <= rx_d; sck_q <= sck_d; cs_q <= cs_d;
      oe_q <= oe_d; rw_q <= rw_d; tw_q <= tw_d; cpol_q <= cpol_d;
      rvalid_o <= rv_d; rdata_o <= rd_d; done_o <= dn_d;
      busy_o <= (st_d != SSP_IDLE);
      sdi_s_q <= {sdi_s_q[0], link.serial_in_line};
      sdo_s_q <= {sdo_s_q[0], link.sdo};
    end
  end

  assign link.sck             = sck_q;
  assign link.chip_select_low = cs_q;
  assign link.h_sdi_o         = tx_q[15];
  assign link.h_sdi_oe        = oe_q;
endmodule : ssp_host
`default_nettype wire

// File: ssp_link_assertions.sv
// concurrent checks on the serial link between host and sensor port
`timescale 1ns/1ps
`default_nettype none
module ssp_link_assertions (
  input  wire logic clk_i,               // host system clock
  input  wire logic arst_n_i,            // async reset, active low
  input  wire logic sck,                 // serial clock from host
  input  wire logic chip_select_low,     // frame select, active low
  input  wire logic protocol_select_pin, // high parks this port
  input  wire logic h_sdi_o,             // host data drive
  input  wire logic h_sdi_oe,            // host data enable
  input  wire logic d_sdi_oe,            // device shared-line enable
  input  wire logic d_sdo_o,             // device output data
  input  wire logic d_sdo_oe,            // device output enable
  input  wire logic serial_in_line       // resolved shared line
);
  logic [7:0] rise_q; // rising sck edges in this frame
  logic       rw_q;   // direction bit of this frame

  // frame tracker on the link clock, cleared while select is high;
  // the count saturates so long bursts never wrap back to a small value
  always_ff @(posedge sck or posedge chip_select_low)
  begin
    if (chip_select_low)
    begin
      rise_q <= 8'h00;
      rw_q   <= 1'b0;
    end
    else
    begin
      if (rise_q == 8'h00) rw_q <= serial_in_line;
      if (rise_q != 8'hff) rise_q <= rise_q + 8'h01;
    end
  end

  // select must hold sck still while the device senses the clock mode
  sequence s_setup_quiet;
    $stable(sck) [*3];
  endsequence

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);

  a_write_sdo_off: assert property (
    (!chip_select_low && rise_q >= 8'h01 && !rw_q) |-> !d_sdo_oe)
    else $error("device output enabled in a write frame");
  a_park_pin_dead: assert property (
    protocol_select_pin |-> (!d_sdo_oe && !d_sdi_oe))
    else $error("device drives while the port is parked");
  a_idle_released: assert property (
    chip_select_low |-> (!d_sdo_oe && !d_sdi_oe))
    else $error("device drives outside a frame");
  a_data_bits_only: assert property (
    (d_sdo_oe || d_sdi_oe) |-> (rw_q && rise_q >= 8'h08))
    else $error("device drives before the data bits");
  a_one_dev_line: assert property (
    !(d_sdo_oe && d_sdi_oe))
    else $error("device drives both data lines");
  a_no_contention: assert property (
    !(h_sdi_oe && d_sdi_oe))
    else $error("host and device both drive the shared line");
  a_dev_edge_stable: assert property (
    ($rose(sck) && d_sdo_oe && $past(d_sdo_oe)) |-> $stable(d_sdo_o))
    else $error("device data changed across a rising sck");
  a_host_edge_stable: assert property (
    ($rose(sck) && h_sdi_oe && $past(h_sdi_oe)) |-> $stable(h_sdi_o))
    else $error("host data changed across a rising sck");
  a_write_len: assert property (
    ($rose(chip_select_low) && !$past(rw_q)) |-> $past(rise_q) == 8'h10)
    else $error("write frame is not sixteen bits");
  a_read_len: assert property (
    ($rose(chip_select_low) && $past(rw_q)) |->
      ($past(rise_q) >= 8'h10 && ($past(rise_q) & 8'h07) == 8'h00))
    else $error("read frame is not whole bytes");
  a_setup_quiet: assert property (
    $fell(chip_select_low) |=> s_setup_quiet)
    else $error("sck moved during select setup");
endmodule : ssp_link_assertions
`default_nettype wire

// File: sensor_spi_slave_port_bench.sv
// self-checking bench: host and sensor port joined through the link
`timescale 1ns/1ps
`default_nettype none
module sensor_spi_slave_port_bench;
  import ssp_pkg::*;
  logic       clk_i = 1'b0, arst_n_i;            // clock and reset
  logic       start_i = 1'b0, rw_i = 1'b0;       // host request
  logic [6:0] addr_i = 7'h00;                    // register address
  logic [7:0] wdata_i = 8'h00;                   // write data
  logic [3:0] nbytes_i = 4'h0;                   // read burst length
  logic       three_wire_i = 1'b0, mode11_i = 1'b0; // link form
  logic       busy_o, rvalid_o, done_o;          // host status
  logic [7:0] rdata_o, wr_data_o;                // read and stored data
  logic [6:0] wr_addr_o;                         // stored address
  logic       wr_valid_o, three_wire_o, mode11_o; // device status
  logic [7:0] rbuf [16];                         // bytes of last read
  logic [7:0] wcnt = 8'h00;                      // device write pulses
  int         rcnt = 0, err_total = 0, num_checks = 0, cyc = 0;
  int         i;

  ssp_link_if link ();
  ssp_host i_ssp_host (.clk_i(clk_i), .arst_n_i(arst_n_i), .link(link),
    .start_i(start_i), .rw_i(rw_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .nbytes_i(nbytes_i), .three_wire_i(three_wire_i),
    .mode11_i(mode11_i), .busy_o(busy_o), .rvalid_o(rvalid_o),
    .rdata_o(rdata_o), .done_o(done_o));
  ssp_device i_ssp_device (.clk_i(clk_i), .arst_n_i(arst_n_i),
    .link(link), .wr_valid_o(wr_valid_o), .wr_addr_o(wr_addr_o),
    .wr_data_o(wr_data_o), .three_wire_o(three_wire_o),
    .mode11_o(mode11_o));
  ssp_link_assertions i_ssp_link_assertions (.clk_i(clk_i),
    .arst_n_i(arst_n_i), .sck(link.sck),
    .chip_select_low(link.chip_select_low),
    .protocol_select_pin(link.protocol_select_pin),
    .h_sdi_o(link.h_sdi_o), .h_sdi_oe(link.h_sdi_oe),
    .d_sdi_oe(link.d_sdi_oe), .d_sdo_o(link.d_sdo_o),
    .d_sdo_oe(link.d_sdo_oe), .serial_in_line(link.serial_in_line));

  // free-running system clock, 5 ns period
  always #2.5 clk_i = ~clk_i;

  // collect read bytes and device write pulses; hang guard
  always @(posedge clk_i)
  begin
    if (rvalid_o === 1'b1) rbuf[rcnt++] = rdata_o;
    if (wr_valid_o === 1'b1) wcnt = wcnt + 8'h01;
    if (++cyc == 20000)
    begin
      err_total++;
      final_report();
    end
  end

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk8

  task automatic chk1(input logic got, input logic exp);
    chk8({7'h00, got}, {7'h00, exp});
  endtask : chk1

  // one host frame; returns once done_o is seen
  task automatic xfer(input logic rw, input logic [6:0] a,
                      input logic [7:0] wd, input logic [3:0] n);
    int k;
    k = 0;
    rcnt = 0;
    @(posedge clk_i);
    #1;
    start_i = 1'b1;
    rw_i = rw;
    addr_i = a;
    wdata_i = wd;
    nbytes_i = n;
    @(posedge clk_i);
    #1;
    start_i = 1'b0;
    chk1(busy_o, 1'b1);
    do
    begin
      @(posedge clk_i);
      #1;
      k++;
    end
    while (done_o !== 1'b1 && k < 3000);
    if (k >= 3000) chk1(1'b0, 1'b1);
  endtask : xfer

  task automatic final_report();
    if (err_total == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : final_report

  initial
  begin
    link.protocol_select_pin = 1'b0;
    // reset falls after time zero so every async reset sees its edge,
    // and before the first clock edge so no flop runs unreset
    #1;
    arst_n_i = 1'b0;
    repeat (10) @(posedge clk_i);
    #1;
    arst_n_i = 1'b1;
    chk1(three_wire_o, 1'b0);
    xfer(SSP_RW_READ, SSP_CTL_ADDR, 8'h00, 4'h1);
    chk8(rbuf[0], SSP_CTL_RESET);
    xfer(SSP_RW_WRITE, 7'h12, 8'ha5, 4'h0);
    chk8({1'b0, wr_addr_o}, 8'h12);
    chk8(wr_data_o, 8'ha5);
    chk8(wcnt, 8'h01);
    xfer(SSP_RW_READ, 7'h12, 8'h00, 4'h1);
    chk8(rbuf[0], 8'ha5);
    // clock mode 11 frames, then back to mode 00
    mode11_i = 1'b1;
    xfer(SSP_RW_WRITE, 7'h13, 8'h3c, 4'h0);
    chk1(mode11_o, 1'b1);
    xfer(SSP_RW_READ, 7'h13, 8'h00, 4'h1);
    chk8(rbuf[0], 8'h3c);
    mode11_i = 1'b0;
    xfer(SSP_RW_READ, 7'h13, 8'h00, 4'h1);
    chk1(mode11_o, 1'b0);
    // burst across the top of the address space
    xfer(SSP_RW_WRITE, 7'h7e, 8'h11, 4'h0);
    xfer(SSP_RW_WRITE, 7'h7f, 8'h22, 4'h0);
    xfer(SSP_RW_WRITE, 7'h00, 8'h33, 4'h0);
    xfer(SSP_RW_READ, 7'h7e, 8'h00, 4'h3);
    chk8(8'(rcnt), 8'h03);
    for (i = 0; i < 3; i++)
      chk8(rbuf[i], 8'h11 * 8'(i + 1));
    // parked port ignores a write and leaves the lines pulled up
    link.protocol_select_pin = 1'b1;
    i = int'(wcnt);
    xfer(SSP_RW_WRITE, 7'h7e, 8'h99, 4'h0);
    chk8(wcnt, 8'(i));
    xfer(SSP_RW_READ, 7'h7e, 8'h00, 4'h1);
    chk8(rbuf[0], 8'hff);
    link.protocol_select_pin = 1'b0;
    xfer(SSP_RW_READ, 7'h7e, 8'h00, 4'h1);
    chk8(rbuf[0], 8'h11);
    // power first, then switch to the shared data line
    xfer(SSP_RW_WRITE, SSP_CTL_ADDR, 8'h01, 4'h0);
    chk1(three_wire_o, 1'b0);
    xfer(SSP_RW_WRITE, SSP_CTL_ADDR, 8'h05, 4'h0);
    chk1(three_wire_o, 1'b1);
    three_wire_i = 1'b1;
    for (i = 0; i < 2; i++)
    begin
      mode11_i = i[0];
      xfer(SSP_RW_WRITE, 7'h7f, 8'hc3 + 8'(i), 4'h0);
      chk8(wr_data_o, 8'hc3 + 8'(i));
      xfer(SSP_RW_READ, 7'h7f, 8'h00, 4'h2);
      chk8(rbuf[0], 8'hc3 + 8'(i));
      chk8(rbuf[1], 8'h33);
    end
    final_report();
  end
endmodule : sensor_spi_slave_port_bench
`default_nettype wire
